//--- rtl/boe_alu.sv
// Combinational result, destination and flag logic of the byte operations
`timescale 1ns/100ps
module boe_alu
  import boe_pkg::*;
(
  boe_alu_if.alu bus
);

  // ----------------------------------------------------------------
  // Result and routing
  // ----------------------------------------------------------------
  always_comb
  begin
    bus.result = ZERO_BYTE;
    bus.f_we = 1'b0;
    bus.w_we = 1'b0;
    bus.z_upd = 1'b0;
    bus.z_val = 1'b0;
    bus.skip = 1'b0;
    case (bus.op)
      COMPLEMENT_FILE_OP:
      begin
        bus.result = ~bus.f_val;
        bus.f_we = (bus.dest == DEST_FILE);
        bus.w_we = (bus.dest == DEST_WORKING);
        bus.z_upd = 1'b1;
        bus.z_val = (bus.result == ZERO_BYTE);
      end
      CLEAR_FILE_OP:
      begin
        bus.f_we = 1'b1;
        bus.z_upd = 1'b1;
        bus.z_val = 1'b1;
      end
      CLEAR_WORKING_OP:
      begin
        bus.w_we = 1'b1;
        bus.z_upd = 1'b1;
        bus.z_val = 1'b1;
      end
      DECREMENT_FILE_OP, DECREMENT_SKIP_ZERO_OP:
      begin
        bus.result = bus.f_val - ONE_BYTE;
        bus.f_we = (bus.dest == DEST_FILE);
        bus.w_we = (bus.dest == DEST_WORKING);
        bus.z_upd = (bus.op == DECREMENT_FILE_OP);
        bus.z_val = (bus.result == ZERO_BYTE);
        bus.skip = (bus.op == DECREMENT_SKIP_ZERO_OP) && (bus.result == ZERO_BYTE);
      end
      default:
      begin
        bus.result = ZERO_BYTE;
      end
    endcase
  end

endmodule // boe_alu

//--- rtl/boe_alu_if.sv
// Signals between the sequencer and the byte operation unit
`timescale 1ns/100ps
interface boe_alu_if;
  import boe_pkg::*;
  boe_op_e op;
  logic dest;
  logic [7:0] f_val;
  logic [7:0] result;
  logic f_we;
  logic w_we;
  logic z_upd;
  logic z_val;
  logic skip;

  modport core (output op, dest, f_val, input result, f_we, w_we, z_upd, z_val, skip);
  modport alu (input op, dest, f_val, output result, f_we, w_we, z_upd, z_val, skip);
endinterface

//--- rtl/boe_apb.sv
// APB slave holding the control register and reading back the status, working and count registers
`timescale 1ns/100ps
module boe_apb
  import boe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic exec_en_r,
  output logic w_wr_r,
  output logic [7:0] w_wr_data_r,
  input wire logic [3:0] status_bits,
  input wire logic [7:0] w_val,
  input wire logic [15:0] op_count
);

  logic commit;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_WORKING) || (a == OFF_COUNT);
  endfunction

  assign commit = psel && penable && pready;

  // ----------------------------------------------------------------
  // One wait state, then answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= !is_mapped(paddr);
      if (paddr == OFF_CTRL)
        prdata <= {31'h0000_0000, exec_en_r};
      else if (paddr == OFF_STATUS)
        prdata <= {28'h000_0000, status_bits};
      else if (paddr == OFF_WORKING)
        prdata <= {24'h00_0000, w_val};
      else if (paddr == OFF_COUNT)
        prdata <= {16'h0000, op_count};
      else
        prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      exec_en_r <= CTRL_EN_RST;
    else if (commit && pwrite && is_mapped(paddr) && paddr == OFF_CTRL)
      exec_en_r <= pwdata[CTRL_EN_BIT];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      w_wr_r <= 1'b0;
      w_wr_data_r <= W_RST;
    end
    else
    begin
      w_wr_r <= commit && pwrite && (paddr == OFF_WORKING);
      w_wr_data_r <= pwdata[7:0];
    end
  end

endmodule // boe_apb

//--- rtl/boe_exec.sv
// Execution of watchdog clear, call via working, complement, clear and decrement operations
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module boe_exec
  import boe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input boe_op_e op_code,
  input wire logic op_dest,
  input wire logic [7:0] file_rd_data,
  input wire logic [14:0] pc_value,
  input wire logic [6:0] pc_high_latch,
  input wire logic timeout_evt,
  input wire logic sleep_evt,
  output logic op_ready,
  output logic discard_fetch,
  output logic file_wr_en,
  output logic [7:0] file_wr_data,
  output logic [7:0] wreg_value,
  output logic zero_flag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic watchdog_counter_clr,
  output logic watchdog_prescaler_clr,
  output logic stack_push,
  output logic [14:0] stack_top,
  output logic pc_load,
  output logic [14:0] pc_load_value
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  boe_alu_if alu_bus ();
  boe_state_e state_r;
  boe_state_e state_nxt;
  logic exec_en;
  logic w_wr;
  logic [7:0] w_wr_data;
  logic accept;
  logic [3:0] status_bits;
  logic [15:0] op_count_r;
  logic [7:0] w_r;
  logic z_r;
  logic to_r;
  logic pd_r;
  logic file_wr_en_r;
  logic [7:0] file_wr_data_r;
  logic wdt_clr_r;
  logic push_r;
  logic [14:0] push_data_r;
  logic pc_load_r;
  logic [14:0] pc_load_value_r;

  // ----------------------------------------------------------------
  // Register bus and operation unit
  // ----------------------------------------------------------------
  boe_apb u_apb (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .exec_en_r(exec_en),
    .w_wr_r(w_wr),
    .w_wr_data_r(w_wr_data),
    .status_bits(status_bits),
    .w_val(w_r),
    .op_count(op_count_r)
  );

  boe_alu u_alu (
    .bus(alu_bus)
  );

  assign alu_bus.op = op_code;
  assign alu_bus.dest = op_dest;
  assign alu_bus.f_val = file_rd_data;

  // ----------------------------------------------------------------
  // Issue and sequencing
  // ----------------------------------------------------------------
  assign op_ready = exec_en && (state_r == EXEC_ST);
  assign accept = op_valid && op_ready && (op_code != NO_OP);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      EXEC_ST:
      begin
        if (accept && op_code == CALL_VIA_WORKING_OP)
          state_nxt = NOP_ST;
        else if (accept && alu_bus.skip)
          state_nxt = NOP_ST;
      end
      NOP_ST:
      begin
        state_nxt = EXEC_ST;
      end
      default:
      begin
        state_nxt = EXEC_ST;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_r <= EXEC_ST;
    else
      state_r <= state_nxt;
  end

  // discard only on the second cycle
  assign discard_fetch = (state_r == NOP_ST);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      op_count_r <= 16'h0000;
    else if (accept)
      op_count_r <= op_count_r + COUNT_STEP;
  end

  // ----------------------------------------------------------------
  // Working register and file write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      w_r <= W_RST;
    else if (accept && alu_bus.w_we)
      w_r <= alu_bus.result;
    else if (w_wr)
      w_r <= w_wr_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      file_wr_en_r <= 1'b0;
      file_wr_data_r <= ZERO_BYTE;
    end
    else
    begin
      file_wr_en_r <= accept && alu_bus.f_we;
      if (accept && alu_bus.f_we)
        file_wr_data_r <= alu_bus.result;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      z_r <= Z_RST;
    else if (accept && alu_bus.z_upd)
      z_r <= alu_bus.z_val;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      to_r <= TO_RST;
      pd_r <= PD_RST;
    end
    else
    begin
      if (accept && op_code == WATCHDOG_CLEAR_OP)
      begin
        to_r <= 1'b1;
        pd_r <= 1'b1;
      end
      else
      begin
        if (timeout_evt)
          to_r <= 1'b0;
        if (sleep_evt)
          pd_r <= 1'b0;
      end
    end
  end

  always_comb
  begin
    status_bits = 4'h0;
    status_bits[STAT_Z_BIT] = z_r;
    status_bits[STAT_TO_BIT] = to_r;
    status_bits[STAT_PD_BIT] = pd_r;
    status_bits[STAT_BUSY_BIT] = (state_r == NOP_ST);
  end

  // ----------------------------------------------------------------
  // Watchdog, stack and program counter controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wdt_clr_r <= 1'b0;
    else
      wdt_clr_r <= accept && (op_code == WATCHDOG_CLEAR_OP);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      push_r <= 1'b0;
      push_data_r <= 15'h0000;
      pc_load_r <= 1'b0;
      pc_load_value_r <= 15'h0000;
    end
    else
    begin
      push_r <= accept && (op_code == CALL_VIA_WORKING_OP);
      pc_load_r <= accept && (op_code == CALL_VIA_WORKING_OP);
      if (accept && op_code == CALL_VIA_WORKING_OP)
      begin
        push_data_r <= pc_value + PC_STEP;
        pc_load_value_r <= {pc_high_latch, w_r};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign file_wr_en = file_wr_en_r;
  assign file_wr_data = file_wr_data_r;
  assign wreg_value = w_r;
  assign zero_flag = z_r;
  assign timeout_flag = to_r;
  assign powerdown_flag = pd_r;
  assign watchdog_counter_clr = wdt_clr_r;
  assign watchdog_prescaler_clr = wdt_clr_r;
  assign stack_push = push_r;
  assign stack_top = push_data_r;
  assign pc_load = pc_load_r;
  assign pc_load_value = pc_load_value_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  wdt_counter_clear_a: assert property (
    accept && op_code == WATCHDOG_CLEAR_OP
    |=> watchdog_counter_clr ##1 (!watchdog_counter_clr || $past(accept && op_code == WATCHDOG_CLEAR_OP)))
    else $error("Watchdog counter clear missing");

  wdt_prescaler_clear_a: assert property (
    accept && op_code == WATCHDOG_CLEAR_OP |=> watchdog_prescaler_clr && watchdog_counter_clr)
    else $error("Prescaler clear not paired with counter clear");

  wdt_flags_set_a: assert property (
    accept && op_code == WATCHDOG_CLEAR_OP |=> timeout_flag && powerdown_flag && $stable(zero_flag))
    else $error("Watchdog clear flags wrong");

  call_push_addr_a: assert property (
    accept && op_code == CALL_VIA_WORKING_OP |=> stack_push && stack_top == $past(pc_value) + PC_STEP)
    else $error("Call return address wrong");

  call_target_a: assert property (
    accept && op_code == CALL_VIA_WORKING_OP
    |=> pc_load && pc_load_value == {$past(pc_high_latch), $past(wreg_value)} && $stable(zero_flag))
    else $error("Call target wrong");

  call_two_cycle_a: assert property (
    accept && op_code == CALL_VIA_WORKING_OP |=> discard_fetch && !op_ready ##1 !discard_fetch)
    else $error("Call not two cycles");

  complement_file_op_result_a: assert property (
    accept && op_code == COMPLEMENT_FILE_OP && op_dest == DEST_FILE
    |=> file_wr_en && file_wr_data == ~$past(file_rd_data)
        && zero_flag == ($past(file_rd_data) == 8'hFF))
    else $error("Complement result wrong");

  dest_working_a: assert property (
    accept && op_dest == DEST_WORKING && (op_code == COMPLEMENT_FILE_OP || op_code == DECREMENT_FILE_OP)
    |=> !file_wr_en && wreg_value == (($past(op_code) == COMPLEMENT_FILE_OP) ? ~$past(file_rd_data)
        : $past(file_rd_data) - ONE_BYTE))
    else $error("Working destination not honoured");

  clear_file_op_zero_a: assert property (
    accept && op_code == CLEAR_FILE_OP |=> file_wr_en && file_wr_data == ZERO_BYTE && zero_flag)
    else $error("Clear file wrong");

  clear_working_op_zero_a: assert property (
    accept && op_code == CLEAR_WORKING_OP |=> !file_wr_en && wreg_value == ZERO_BYTE && zero_flag)
    else $error("Clear working wrong");

  decrement_file_op_result_a: assert property (
    accept && op_code == DECREMENT_FILE_OP && op_dest == DEST_FILE
    |=> file_wr_data == $past(file_rd_data) - ONE_BYTE && zero_flag == ($past(file_rd_data) == ONE_BYTE))
    else $error("Decrement result wrong");

  decrement_skip_zero_op_flags_a: assert property (
    accept && op_code == DECREMENT_SKIP_ZERO_OP |=> $stable(zero_flag) && $stable(timeout_flag))
    else $error("Decrement skip changed flags");

  decrement_skip_zero_op_skip_a: assert property (
    accept && op_code == DECREMENT_SKIP_ZERO_OP && file_rd_data == ONE_BYTE |=> discard_fetch ##1 !discard_fetch)
    else $error("Zero result did not skip");

  decrement_skip_zero_op_noskip_a: assert property (
    accept && op_code == DECREMENT_SKIP_ZERO_OP && file_rd_data != ONE_BYTE |=> !discard_fetch)
    else $error("Nonzero result skipped");

  single_cycle_a: assert property (
    accept && (op_code == COMPLEMENT_FILE_OP || op_code == CLEAR_FILE_OP
               || op_code == CLEAR_WORKING_OP || op_code == DECREMENT_FILE_OP)
    |=> state_r == EXEC_ST)
    else $error("Single cycle operation stalled");

endmodule // boe_exec

//--- rtl/boe_pkg.sv
// Shared constants and types for the byte operation execution block
package boe_pkg;

  // ----------------------------------------------------------------
  // Operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NO_OP,
    WATCHDOG_CLEAR_OP,
    CALL_VIA_WORKING_OP,
    COMPLEMENT_FILE_OP,
    CLEAR_FILE_OP,
    CLEAR_WORKING_OP,
    DECREMENT_FILE_OP,
    DECREMENT_SKIP_ZERO_OP
  } boe_op_e;

  typedef enum logic {
    EXEC_ST,
    NOP_ST
  } boe_state_e;

  // ----------------------------------------------------------------
  // Data path values
  // ----------------------------------------------------------------
  localparam logic DEST_WORKING = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [14:0] PC_STEP = 15'h0001;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic Z_RST = 1'b0;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_WORKING = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int STAT_Z_BIT = 0;
  localparam int STAT_TO_BIT = 1;
  localparam int STAT_PD_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;

endpackage

//--- tb/tb_top.sv
// Self-checking testbench for the byte operation execution block
`timescale 1ns/100ps
module tb_top
  import boe_pkg::*;
;
  logic clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic op_valid;
  boe_op_e op_code;
  logic op_dest;
  logic [7:0] file_rd_data;
  logic [14:0] pc_value;
  logic [6:0] pc_high_latch;
  logic timeout_evt;
  logic sleep_evt;
  logic op_ready;
  logic discard_fetch;
  logic file_wr_en;
  logic [7:0] file_wr_data;
  logic [7:0] wreg_value;
  logic zero_flag;
  logic timeout_flag;
  logic powerdown_flag;
  logic watchdog_counter_clr;
  logic watchdog_prescaler_clr;
  logic stack_push;
  logic [14:0] stack_top;
  logic pc_load;
  logic [14:0] pc_load_value;
  logic [31:0] rd;
  logic err;
  int errors;
  int comparisons;

  boe_exec u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
    .op_code(op_code), .op_dest(op_dest), .file_rd_data(file_rd_data), .pc_value(pc_value),
    .pc_high_latch(pc_high_latch), .timeout_evt(timeout_evt), .sleep_evt(sleep_evt), .op_ready(op_ready),
    .discard_fetch(discard_fetch), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
    .wreg_value(wreg_value), .zero_flag(zero_flag), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .watchdog_counter_clr(watchdog_counter_clr),
    .watchdog_prescaler_clr(watchdog_prescaler_clr), .stack_push(stack_push), .stack_top(stack_top),
    .pc_load(pc_load), .pc_load_value(pc_load_value));

  // ----------------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Counts: comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Offer one operation; returns in the cycle after the accept edge
  task automatic do_op(input boe_op_e c, input logic d, input logic [7:0] f);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_dest <= d;
    file_rd_data <= f;
    @(posedge clk);
    op_valid <= 1'b0;
    op_code <= NO_OP;
    #1;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic chk_res(input logic d, input logic [7:0] r, input logic z);
    chk(file_wr_en, d);
    if (d == DEST_FILE)
      chk(file_wr_data, r);
    else
      chk(wreg_value, r);
    chk(zero_flag, z);
    chk(discard_fetch, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_apb();
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    apb(1'b1, OFF_WORKING, 32'h0000_003C);
    apb(1'b0, OFF_WORKING, 32'h0000_0000);
    chk(rd, 32'h0000_003C);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
  endtask

  task automatic t_wdt();
    logic zb;
    @(posedge clk);
    timeout_evt <= 1'b1;
    sleep_evt <= 1'b1;
    @(posedge clk);
    timeout_evt <= 1'b0;
    sleep_evt <= 1'b0;
    step();
    chk({timeout_flag, powerdown_flag}, 2'b00);
    zb = zero_flag;
    do_op(WATCHDOG_CLEAR_OP, 1'b0, 8'h00);
    chk(watchdog_counter_clr, 1'b1);
    chk(watchdog_prescaler_clr, 1'b1);
    chk({timeout_flag, powerdown_flag, zero_flag}, {2'b11, zb});
    step();
    chk({watchdog_counter_clr, watchdog_prescaler_clr}, 2'b00);
  endtask

  task automatic t_call();
    logic zb;
    pc_value <= 15'h1234;
    pc_high_latch <= 7'h55;
    zb = zero_flag;
    do_op(CALL_VIA_WORKING_OP, 1'b0, 8'h00);
    chk({stack_push, stack_top}, {1'b1, 15'h1234 + PC_STEP});
    chk({pc_load, pc_load_value}, {1'b1, 7'h55, 8'h3C});
    chk({zero_flag, discard_fetch, op_ready}, {zb, 2'b10});
    step();
    chk({stack_push, pc_load, discard_fetch, op_ready}, 4'b0001);
  endtask

  task automatic t_alu();
    do_op(COMPLEMENT_FILE_OP, 1'b1, 8'hFF);
    chk_res(1'b1, 8'h00, 1'b1);
    do_op(COMPLEMENT_FILE_OP, 1'b0, 8'h5A);
    chk_res(1'b0, 8'hA5, 1'b0);
    do_op(CLEAR_FILE_OP, 1'b1, 8'h77);
    chk_res(1'b1, 8'h00, 1'b1);
    do_op(DECREMENT_FILE_OP, 1'b1, 8'h00);
    chk_res(1'b1, 8'hFF, 1'b0);
    do_op(CLEAR_WORKING_OP, 1'b0, 8'h00);
    chk_res(1'b0, 8'h00, 1'b1);
    do_op(DECREMENT_FILE_OP, 1'b0, 8'h81);
    chk_res(1'b0, 8'h80, 1'b0);
    do_op(DECREMENT_FILE_OP, 1'b0, 8'h01);
    chk_res(1'b0, 8'h00, 1'b1);
  endtask

  task automatic t_skip();
    do_op(CLEAR_FILE_OP, 1'b1, 8'h00);
    do_op(DECREMENT_SKIP_ZERO_OP, 1'b0, 8'h03);
    chk_res(1'b0, 8'h02, 1'b1);
    chk(op_ready, 1'b1);
    do_op(COMPLEMENT_FILE_OP, 1'b0, 8'hF0);
    do_op(DECREMENT_SKIP_ZERO_OP, 1'b1, 8'h01);
    chk({file_wr_en, file_wr_data, zero_flag}, {1'b1, 8'h00, 1'b0});
    chk({discard_fetch, op_ready}, 2'b10);
    step();
    chk({discard_fetch, op_ready, file_wr_en}, 3'b010);
    do_op(DECREMENT_SKIP_ZERO_OP, 1'b0, 8'h01);
    chk({wreg_value, zero_flag, discard_fetch}, {8'h00, 1'b0, 1'b1});
  endtask

  task automatic t_ctrl();
    apb(1'b1, OFF_WORKING, 32'h0000_0081);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(op_ready, 1'b0);
    do_op(CLEAR_WORKING_OP, 1'b0, 8'h00);
    chk({wreg_value, file_wr_en, discard_fetch}, {8'h81, 2'b00});
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    apb(1'b0, OFF_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_000E);
    chk(op_ready, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    op_valid = 1'b0;
    op_code = NO_OP;
    op_dest = 1'b0;
    file_rd_data = 8'h00;
    pc_value = 15'h0000;
    pc_high_latch = 7'h00;
    timeout_evt = 1'b0;
    sleep_evt = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({wreg_value, zero_flag, timeout_flag, powerdown_flag, op_ready}, {W_RST, Z_RST, TO_RST, PD_RST, 1'b1});
    t_apb();
    t_call();
    t_wdt();
    t_alu();
    t_skip();
    t_ctrl();
    step();
    close_out();
  end

  initial
  begin
    #(25 * 2000);
    errors++;
    close_out();
  end
endmodule // tb_top
